/* File: verilog/stxc_core.sv */
// serial transmitter core: registers, one-entry buffer, shifter and flags
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1: with transmit enable set the core drives the serial output pin.
// RULE2: in synchronous slave mode the external clock pin paces transmitted bits.
// RULE3: a data location write loads the buffer and starts transmission.
// RULE4: buffer moves to shifter when idle or right after the last stop bit.
// RULE5: the shifter sends one whole frame at the selected bit rate.
// RULE6: data bits above the configured character size are ignored.
// RULE7: software writes the ninth bit before the low byte.
// RULE8: buffer-empty flag is one while buffer empty, zero while it holds data.
// RULE9: writing the data location clears the buffer-empty flag.
// RULE10: buffer-empty interrupt requested while flag set and enabled.
// RULE11: handler writes new data or disables the buffer-empty interrupt.
// RULE12: complete flag sets when frame is out and buffer holds nothing.
// RULE13: complete flag clears on interrupt service or by writing one.
// RULE14: complete interrupt requested when flag set and enabled.
// RULE15: software writes zero at the buffer-empty position.
// RULE16: software configures rate, mode and format before transmitting.
// RULE17: software selects standard or enhanced mode first.
// RULE18: software changes rate or format only with no transfer ongoing.
// RULE19: software clears complete flag before each data write when polling it.
// RULE20: software keeps interrupts globally off during initialization.
// RULE21: frame is low start, data lsb first, one or two high stops.
// RULE22: parity bit goes after the last data bit, before the stops.
// RULE23: disabling waits until shifter and buffer are empty, then releases pin.
// RULE24: bit time is generator output over 16, 8 or 2 by mode.
// RULE25: enabled and idle, the output pin stays high.
// RULE26: after reset buffer-empty reads one and complete reads zero.
module stxc_core
   import stxc_pkg::*;
#(
   parameter int DIVW = 12
) (
   input  wire logic       mclk,        // system clock, 100 MHz
   input  wire logic       rstn,        // async reset, active low
   input  wire logic [2:0] addr,        // register address
   input  wire logic [7:0] wdata,       // write data
   input  wire logic       wr,          // write strobe
   input  wire logic       rd,          // read strobe
   output logic      [7:0] rdata,       // read data, cycle after rd
   input  wire logic       gie,         // global interrupt enable
   input  wire logic       txc_ack,     // complete interrupt being serviced
   input  wire logic       xck_in,      // ext_serial_clock_pin input
   output logic            tx_buffer_empty_flag_irq,    // buffer-empty interrupt request
   output logic            txc_irq,     // transmit-complete interrupt request
   output logic            txd_o,       // serial_out_pin level
   output logic            txd_oe       // serial_out_pin taken from port logic
);
   typedef enum logic [1:0] {STXC_IDLE, STXC_SHIFT} stxc_state_t;

   logic [7:0] csb_r, csb_nxt, fmt_r, fmt_nxt;
   logic [DIVW-1:0] div_r, div_nxt;
   logic       dbl_r, dbl_nxt;
   logic [8:0] buf_r, buf_nxt;
   logic       full_r, full_nxt;
   logic       txc_r, txc_nxt;
   logic [11:0] sh_r, sh_nxt;          // start, data, parity and stops
   logic [3:0] left_r, left_nxt;
   stxc_state_t st_r, st_nxt;
   logic       en_r, en_nxt;
   logic       txd_nxt, oe_nxt, ui_nxt, ti_nxt;
   logic [7:0] rdata_nxt;
   logic       xs1_r, xs2_r, xs3_r;
   logic       bit_tick;
   logic       xck_edge, step, wr_data, sync, slave;
   logic [2:0] csz;
   logic [3:0] nbits, ratio;
   logic [8:0] dmask, dat;
   logic       par;

   // two-stage synchroniser, then an edge detector behind it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         xs1_r <= 1'b0;
         xs2_r <= 1'b0;
         xs3_r <= 1'b0;
      end else begin
         xs1_r <= xck_in;
         xs2_r <= xs1_r;
         xs3_r <= xs2_r;
      end
   end

   assign sync     = fmt_r[STXC_FMT_SYNC];
   assign slave    = sync && !fmt_r[STXC_FMT_XMST];
   assign csz      = {csb_r[STXC_CSB_CSZ2], fmt_r[STXC_FMT_CSZ1], fmt_r[STXC_FMT_CSZ0]};
   assign ratio    = sync ? STXC_DIV_SYNC : (dbl_r ? STXC_DIV_DBL : STXC_DIV_NORM);
   assign xck_edge = xs2_r && !xs3_r;                       // data change on rising edge
   assign step     = slave ? xck_edge : bit_tick;           // see RULE2
   assign wr_data  = wr && addr == STXC_OFS_DATA;

   stxc_baud #(.DIVW(DIVW)) u_baud (
      .mclk     (mclk),
      .rstn     (rstn),
      .divisor  (div_r),
      .reload   (wr && addr == STXC_OFS_BAUDL),
      .ratio    (ratio),
      .run      (st_r == STXC_SHIFT),
      .bit_tick (bit_tick)
   );

   // frame geometry from the format bits
   always_comb begin
      case (csz)
         3'h0:    nbits = 4'h5;
         3'h1:    nbits = 4'h6;
         3'h2:    nbits = 4'h7;
         3'h7:    nbits = 4'h9;
         default: nbits = 4'h8;
      endcase
      dmask = 9'h1ff >> (4'h9 - nbits);
      dat   = buf_r & dmask;                                // see RULE6
      par   = (^dat) ^ fmt_r[STXC_FMT_PM0];
   end

   // register file
   always_comb begin
      csb_nxt = csb_r;
      fmt_nxt = fmt_r;
      div_nxt = div_r;
      dbl_nxt = dbl_r;
      rdata_nxt = 8'h00;
      if (wr) begin
         if (addr == STXC_OFS_CSA) begin
            dbl_nxt = wdata[STXC_CSA_DBL];
         end else if (addr == STXC_OFS_CSB) begin
            csb_nxt = wdata;
         end else if (addr == STXC_OFS_FMT) begin
            fmt_nxt = wdata;
         end else if (addr == STXC_OFS_BAUDL) begin
            div_nxt[7:0] = wdata;
         end else if (addr == STXC_OFS_BAUDH) begin
            div_nxt[DIVW-1:8] = wdata[DIVW-9:0];
         end
      end
      if (rd) begin
         if (addr == STXC_OFS_CSA) begin
            rdata_nxt[STXC_CSA_TXC]  = txc_r;
            rdata_nxt[STXC_CSA_TX_BUFFER_EMPTY_FLAG] = !full_r;              // see RULE8
            rdata_nxt[STXC_CSA_DBL]  = dbl_r;
         end else if (addr == STXC_OFS_CSB) begin
            rdata_nxt = csb_r;
         end else if (addr == STXC_OFS_FMT) begin
            rdata_nxt = fmt_r;
         end else if (addr == STXC_OFS_BAUDL) begin
            rdata_nxt = div_r[7:0];
         end else if (addr == STXC_OFS_BAUDH) begin
            rdata_nxt = {{(16-DIVW){1'b0}}, div_r[DIVW-1:8]};
         end
      end
   end

   // buffer, shifter and flags
   always_comb begin
      buf_nxt  = buf_r;
      full_nxt = full_r;
      txc_nxt  = txc_r;
      sh_nxt   = sh_r;
      left_nxt = left_r;
      st_nxt   = st_r;
      en_nxt   = en_r;
      if (wr_data) begin
         buf_nxt  = {csb_r[STXC_CSB_TX_NINTH_BIT], wdata};           // see RULE3
         full_nxt = 1'b1;                                    // see RULE9
      end
      // clear first so that a set in the same cycle wins
      if ((wr && addr == STXC_OFS_CSA && wdata[STXC_CSA_TXC]) || txc_ack) begin
         txc_nxt = 1'b0;                                     // see RULE13
      end
      case (st_r)
         STXC_IDLE: begin
            // a pending character still leaves after the enable bit drops
            if (full_r && (csb_r[STXC_CSB_TX_ENABLE_BIT] || en_r)) begin // see RULE4 RULE23
               st_nxt = STXC_SHIFT;
            end
         end
         STXC_SHIFT: begin
            if (step) begin
               sh_nxt   = {1'b1, sh_r[11:1]};                // see RULE21
               left_nxt = left_r - 1'b1;
               if (left_r == 4'h1) begin
                  st_nxt = STXC_IDLE;
                  if (!full_r) begin
                     txc_nxt = 1'b1;                         // see RULE12
                  end
               end
            end
         end
         default: st_nxt = STXC_IDLE;
      endcase
      // load: start bit, data lsb first, optional parity, stops (all high above)
      if (st_nxt == STXC_SHIFT && st_r == STXC_IDLE
          || st_r == STXC_SHIFT && step && left_r == 4'h1 && full_r
             && (csb_r[STXC_CSB_TX_ENABLE_BIT] || en_r)) begin
         st_nxt   = STXC_SHIFT;                              // see RULE4
         sh_nxt   = 12'hfff;
         sh_nxt[0] = 1'b0;
         sh_nxt[9:1] = dat | ~dmask;
         if (fmt_r[STXC_FMT_PM1]) begin
            sh_nxt[nbits+4'h1] = par;                        // see RULE22
         end
         left_nxt = 4'h2 + nbits + {3'h0, fmt_r[STXC_FMT_PM1]}
                    + {3'h0, fmt_r[STXC_FMT_STOP2]};         // see RULE5
         full_nxt = wr_data;
      end
      // the pin is held until both shifter and buffer drain
      if (csb_r[STXC_CSB_TX_ENABLE_BIT]) begin
         en_nxt = 1'b1;                                      // see RULE1
      end else if (st_nxt == STXC_IDLE && !full_nxt) begin
         en_nxt = 1'b0;                                      // see RULE23
      end
      txd_nxt  = (st_nxt == STXC_SHIFT) ? sh_nxt[0] : 1'b1;  // see RULE25
      oe_nxt   = en_nxt;
      ui_nxt   = gie && csb_r[STXC_CSB_BUFFER_EMPTY_IRQ_ENABLE] && !full_nxt;  // see RULE10
      ti_nxt   = gie && csb_r[STXC_CSB_TX_DONE_IRQ_ENABLE] && txc_nxt;    // see RULE14
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         csb_r    <= STXC_CSB_RST;
         fmt_r    <= STXC_FMT_RST;
         div_r    <= '0;
         dbl_r    <= 1'b0;
         buf_r    <= 9'h000;
         full_r   <= 1'b0;                                   // see RULE26
         txc_r    <= 1'b0;
         sh_r     <= 12'hfff;
         left_r   <= 4'h0;
         st_r     <= STXC_IDLE;
         en_r     <= 1'b0;
         rdata    <= 8'h00;
         txd_o    <= 1'b1;
         txd_oe   <= 1'b0;
         tx_buffer_empty_flag_irq <= 1'b0;
         txc_irq  <= 1'b0;
      end else begin
         csb_r    <= csb_nxt;
         fmt_r    <= fmt_nxt;
         div_r    <= div_nxt;
         dbl_r    <= dbl_nxt;
         buf_r    <= buf_nxt;
         full_r   <= full_nxt;
         txc_r    <= txc_nxt;
         sh_r     <= sh_nxt;
         left_r   <= left_nxt;
         st_r     <= st_nxt;
         en_r     <= en_nxt;
         rdata    <= rdata_nxt;
         txd_o    <= txd_nxt;
         txd_oe   <= oe_nxt;
         tx_buffer_empty_flag_irq <= ui_nxt;
         txc_irq  <= ti_nxt;
      end
   end

   property p_data_write_fills;
      @(posedge mclk) disable iff (!rstn)
      wr_data && st_r == STXC_SHIFT && !(step && left_r == 4'h1) |=> full_r;
   endproperty
   a_data_write_fills: assert property (p_data_write_fills)   // see RULE9
      else $error("data write did not fill the buffer");

   property p_idle_high;
      @(posedge mclk) disable iff (!rstn)
      st_r == STXC_IDLE && $past(st_r) == STXC_IDLE |-> txd_o;
   endproperty
   a_idle_high: assert property (p_idle_high)                 // see RULE25
      else $error("line not high while idle");

   property p_start_low;
      @(posedge mclk) disable iff (!rstn)
      $rose(st_r == STXC_SHIFT) |-> !txd_o;
   endproperty
   a_start_low: assert property (p_start_low)                 // see RULE21
      else $error("frame did not open with a low bit");

   property p_txc_on_end;
      @(posedge mclk) disable iff (!rstn)
      st_r == STXC_SHIFT && step && left_r == 4'h1 && !full_r |=> txc_r;
   endproperty
   a_txc_on_end: assert property (p_txc_on_end)               // see RULE12
      else $error("complete flag missed end of frame");

   property p_txc_clear;
      @(posedge mclk) disable iff (!rstn)
      txc_ack && !(st_r == STXC_SHIFT && step) |=> !txc_r;
   endproperty
   a_txc_clear: assert property (p_txc_clear)                 // see RULE13
      else $error("complete flag not cleared on service");

   property p_pin_held;
      @(posedge mclk) disable iff (!rstn)
      (full_r || st_r == STXC_SHIFT && !(step && left_r == 4'h1)) && en_r |=> txd_oe;
   endproperty
   a_pin_held: assert property (p_pin_held)                   // see RULE23
      else $error("pin released with data pending");

   property p_enable_drives;
      @(posedge mclk) disable iff (!rstn)
      csb_r[STXC_CSB_TX_ENABLE_BIT] |=> txd_oe;
   endproperty
   a_enable_drives: assert property (p_enable_drives)         // see RULE1
      else $error("enabled but pin not driven");

   property p_tx_buffer_empty_flag_irq;
      @(posedge mclk) disable iff (!rstn)
      gie && csb_r[STXC_CSB_BUFFER_EMPTY_IRQ_ENABLE] && !full_r && !wr_data ##1 !full_r |-> tx_buffer_empty_flag_irq;
   endproperty
   a_tx_buffer_empty_flag_irq: assert property (p_tx_buffer_empty_flag_irq)                   // see RULE10
      else $error("buffer-empty request missing");

   property p_no_move_when_busy;
      @(posedge mclk) disable iff (!rstn)
      st_r == STXC_SHIFT && !step && full_r && !wr_data |=> full_r;
   endproperty
   a_no_move_when_busy: assert property (p_no_move_when_busy) // see RULE4
      else $error("buffer moved mid frame");
endmodule : stxc_core
`default_nettype wire

/* File: verilog/stxc_pkg.sv */
// package: register offsets, field positions, reset values and divider ratios
package stxc_pkg;
   // register offsets on the plain register port
   localparam logic [2:0] STXC_OFS_DATA   = 3'h0;  // serial_data_location
   localparam logic [2:0] STXC_OFS_CSA    = 3'h1;  // ctrl_status_first
   localparam logic [2:0] STXC_OFS_CSB    = 3'h2;  // ctrl_status_second
   localparam logic [2:0] STXC_OFS_FMT    = 3'h3;  // mode and frame format
   localparam logic [2:0] STXC_OFS_BAUDL  = 3'h4;  // baud_divisor low byte
   localparam logic [2:0] STXC_OFS_BAUDH  = 3'h5;  // baud_divisor high nibble
   // ctrl_status_first fields
   localparam int STXC_CSA_TXC   = 6;   // tx_complete_flag
   localparam int STXC_CSA_TX_BUFFER_EMPTY_FLAG  = 5;   // tx_buffer_empty_flag
   localparam int STXC_CSA_DBL   = 1;   // double_speed_bit
   // ctrl_status_second fields
   localparam int STXC_CSB_TX_DONE_IRQ_ENABLE = 6;   // tx_done_irq_enable
   localparam int STXC_CSB_BUFFER_EMPTY_IRQ_ENABLE = 5;   // buffer_empty_irq_enable
   localparam int STXC_CSB_TX_ENABLE_BIT  = 3;   // tx_enable_bit
   localparam int STXC_CSB_CSZ2  = 2;   // char_size_field bit 2
   localparam int STXC_CSB_TX_NINTH_BIT  = 0;   // tx_ninth_bit
   // format register fields
   localparam int STXC_FMT_SYNC  = 6;   // synchronous mode
   localparam int STXC_FMT_PM1   = 5;   // parity_mode_field high bit
   localparam int STXC_FMT_PM0   = 4;   // parity_mode_field low bit (odd)
   localparam int STXC_FMT_STOP2 = 3;   // stop_bits_select
   localparam int STXC_FMT_CSZ1  = 2;
   localparam int STXC_FMT_CSZ0  = 1;
   localparam int STXC_FMT_XMST  = 0;   // sync master: clock from baud generator
   // reset values
   localparam logic [7:0] STXC_CSB_RST  = 8'h00;
   localparam logic [7:0] STXC_FMT_RST  = 8'h06;  // 8 data bits, async
   localparam logic [2:0] STXC_CSZ_NINE = 3'h7;
   // transmitter divide ratios of the baud generator output
   localparam logic [3:0] STXC_DIV_NORM = 4'hf;   // 16
   localparam logic [3:0] STXC_DIV_DBL  = 4'h7;   // 8
   localparam logic [3:0] STXC_DIV_SYNC = 4'h1;   // 2
endpackage : stxc_pkg

/* File: verilog/stxc_baud.sv */
// baud generator and bit-rate enable for the transmitter
`timescale 1ns/10ps
`default_nettype none
module stxc_baud
   import stxc_pkg::*;
#(
   parameter int DIVW = 12
) (
   input  wire logic            mclk,       // system clock
   input  wire logic            rstn,       // async reset, active low
   input  wire logic [DIVW-1:0] divisor,    // baud_divisor
   input  wire logic            reload,     // divisor low byte written
   input  wire logic [3:0]      ratio,      // transmitter divide minus one
   input  wire logic            run,        // shifter busy
   output logic                 bit_tick    // one-cycle pulse per bit time
);
   logic [DIVW-1:0] cnt_r, cnt_nxt;
   logic [3:0]      sub_r, sub_nxt;
   logic            tick_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      sub_nxt  = sub_r;
      tick_nxt = 1'b0;
      if (reload || cnt_r == '0) begin
         cnt_nxt = divisor;
      end else begin
         cnt_nxt = cnt_r - 1'b1;
      end
      // restart the sub-divider when idle so the first bit is full length
      if (!run) begin
         sub_nxt = ratio;
      end else if (cnt_r == '0) begin
         if (sub_r == 4'h0) begin
            sub_nxt  = ratio;
            tick_nxt = 1'b1;                                 // see RULE24
         end else begin
            sub_nxt = sub_r - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_r    <= '0;
         sub_r    <= STXC_DIV_NORM;
         bit_tick <= 1'b0;
      end else begin
         cnt_r    <= cnt_nxt;
         sub_r    <= sub_nxt;
         bit_tick <= tick_nxt;
      end
   end
endmodule : stxc_baud
`default_nettype wire

/* File: verification/stxc_rx_model.sv */
// remote serial receiver model watching the transmit line
`timescale 1ns/10ps
`default_nettype none
module stxc_rx_model (
   input  wire logic        mclk,      // system clock
   input  wire logic        txd_o,     // serial line level
   input  wire logic        txd_oe,    // line driven by the core
   input  var  int          bit_cyc,   // clock cycles per bit
   input  var  int          nbits,     // bits after the start bit
   output logic      [15:0] frame,     // bits after start from bit 0, start sample in bit 15
   output var  int          n_frames   // frames seen so far
);
   initial begin
      frame = 16'h0000;
      n_frames = 0;
      forever begin
         @(negedge txd_o iff txd_oe === 1'b1);
         // mid-bit sampling tolerates a cycle of launch skew
         repeat (bit_cyc / 2) @(posedge mclk);
         frame = 16'h0000;
         frame[15] = txd_o;
         for (int i = 0; i < nbits; i++) begin
            repeat (bit_cyc) @(posedge mclk);
            frame[i] = txd_o;
         end
         n_frames++;
      end
   end
endmodule : stxc_rx_model
`default_nettype wire

/* File: verification/serial_transmitter_core_tb.sv */
// self-checking testbench of the serial transmitter core
`timescale 1ns/10ps
`default_nettype none
module serial_transmitter_core_tb;
   import stxc_pkg::*;
   logic        mclk, rstn, wr, rd, gie, txc_ack, xck_in, tx_buffer_empty_flag_irq, txc_irq, txd_o, txd_oe;
   logic [2:0]  addr;
   logic [7:0]  wdata, rdata, rv, csa_v, csb_v;
   logic [15:0] frame;
   logic [31:0] seed;
   logic [8:0]  d;
   logic        v0;
   int          bit_cyc, nbits, n_frames, err_total, n_compared, n, par, s2, dbl, md, i;

   stxc_core #(.DIVW(12)) stxc_core_i (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .gie(gie), .txc_ack(txc_ack), .xck_in(xck_in),
      .tx_buffer_empty_flag_irq(tx_buffer_empty_flag_irq), .txc_irq(txc_irq), .txd_o(txd_o), .txd_oe(txd_oe));
   stxc_rx_model stxc_rx_model_i (.mclk(mclk), .txd_o(txd_o), .txd_oe(txd_oe),
      .bit_cyc(bit_cyc), .nbits(nbits), .frame(frame), .n_frames(n_frames));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function automatic logic [15:0] exp_frame(input logic [8:0] dv, input int nb, pm, st2);
      logic [15:0] f;
      int          k;
      f = 16'h0000;
      for (k = 0; k < nb; k++) f[k] = dv[k];
      k = nb;
      if (pm != 0) begin
         f[k] = (^(dv & 9'((10'h001 << nb) - 1))) ^ (pm == 2);
         k++;
      end
      f[k] = 1'b1;
      if (st2 != 0) f[k+1] = 1'b1;
      return f;
   endfunction : exp_frame
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wreg(input logic [2:0] a, input logic [7:0] dw);
      @(posedge mclk); wr <= 1'b1; addr <= a; wdata <= dw;
      @(posedge mclk); wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [2:0] a);
      @(posedge mclk); rd <= 1'b1; addr <= a;
      @(posedge mclk); rd <= 1'b0;
      #1 rv = rdata;
   endtask : rreg
   task automatic ticks(input int c);
      repeat (c) @(posedge mclk);
   endtask : ticks
   task automatic wait_frames(input int n0);
      for (int t = 0; t < 4000 && n_frames <= n0; t++) @(posedge mclk);
      chk("frame_count", 16'h0001, 16'(n_frames > n0));
   endtask : wait_frames
   task automatic setup(input int nb, pm, st2, dv, mo);
      logic [2:0] cz;
      cz = (nb == 9) ? STXC_CSZ_NINE : 3'(nb - 5);
      wreg(STXC_OFS_FMT, {1'b0, mo[0], pm != 0, pm == 2, st2[0], cz[1:0], mo[0]});
      wreg(STXC_OFS_BAUDH, 8'h00);
      wreg(STXC_OFS_BAUDL, 8'h01);
      csa_v = {6'h00, dv[0], 1'b0};
      wreg(STXC_OFS_CSA, csa_v);
      csb_v = {5'h01, cz[2], 2'h0};
      wreg(STXC_OFS_CSB, csb_v);
      bit_cyc = (mo != 0) ? 4 : ((dv != 0) ? 16 : 32);
      nbits = nb + (pm != 0) + 1 + st2;
   endtask : setup
   task automatic send(input logic [8:0] dv);
      csb_v[STXC_CSB_TX_NINTH_BIT] = dv[8];
      wreg(STXC_OFS_CSB, csb_v);
      wreg(STXC_OFS_CSA, csa_v | 8'h40);
      wreg(STXC_OFS_DATA, dv[7:0]);
   endtask : send
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", err_total, n_compared);
      if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_sim

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      repeat (60000) @(posedge mclk);
      err_total++;
      end_sim();
   end
   initial begin
      {rstn, wr, rd, txc_ack, xck_in, addr, wdata} = '0;
      gie = 1'b0;
      seed = 32'hc111a93d;
      {err_total, n_compared, bit_cyc, nbits} = {32'd0, 32'd0, 32'd32, 32'd10};
      ticks(6);
      rstn <= 1'b1;
      rreg(STXC_OFS_CSA); chk("csa_reset", 16'h0020, 16'(rv & 8'h60));
      rreg(STXC_OFS_FMT); chk("fmt_reset", 16'(STXC_FMT_RST), 16'(rv));
      rreg(3'h7); chk("unmapped", 16'h0000, 16'(rv));
      chk("oe_reset", 16'h0000, 16'(txd_oe));
      for (int k = 0; k < 10; k++) begin
         seed = xs(seed);
         n = 5 + int'(seed % 5);
         par = int'((seed >> 4) % 3);
         s2 = int'(seed[8]);
         md = (k == 9);
         // double speed only has meaning in asynchronous mode
         dbl = md ? 0 : int'(seed[9]);
         setup(n, par, s2, dbl, md);
         seed = xs(seed);
         d = seed[8:0];
         // the pin is taken one cycle after the enable bit lands
         ticks(2);
         chk("oe_on", 16'h0001, 16'(txd_oe));
         chk("idle_high", 16'h0001, 16'(txd_o));
         i = n_frames;
         send(d);
         rreg(STXC_OFS_CSA); chk("txc_cleared", 16'h0000, 16'(rv & 8'h40));
         wait_frames(i);
         chk("frame", exp_frame(d, n, par, s2), frame);
         ticks(bit_cyc + 4);
         rreg(STXC_OFS_CSA); chk("done_flags", 16'h0060, 16'(rv & 8'h60));
      end
      setup(8, 0, 0, 0, 0);
      i = n_frames;
      send(9'h0a5);
      wreg(STXC_OFS_DATA, 8'h3c);
      rreg(STXC_OFS_CSA); chk("buf_full", 16'h0000, 16'(rv & 8'h60));
      wait_frames(i);
      chk("frame_a", exp_frame(9'h0a5, 8, 0, 0), frame);
      ticks(19);
      chk("next_start", 16'h0000, 16'(txd_o));
      rreg(STXC_OFS_CSA); chk("no_done_between", 16'h0020, 16'(rv & 8'h60));
      wait_frames(i + 1);
      chk("frame_b", exp_frame(9'h03c, 8, 0, 0), frame);
      ticks(bit_cyc + 4);
      gie <= 1'b1;
      csb_v = csb_v | 8'h60;
      wreg(STXC_OFS_CSB, csb_v);
      ticks(3);
      chk("tx_buffer_empty_flag_irq", 16'h0001, 16'(tx_buffer_empty_flag_irq));
      chk("txc_irq", 16'h0001, 16'(txc_irq));
      @(posedge mclk); txc_ack <= 1'b1;
      @(posedge mclk); txc_ack <= 1'b0;
      ticks(3);
      chk("txc_irq_ack", 16'h0000, 16'(txc_irq));
      rreg(STXC_OFS_CSA); chk("txc_ack_flag", 16'h0020, 16'(rv & 8'h60));
      gie <= 1'b0;
      ticks(3);
      chk("tx_buffer_empty_flag_gie_off", 16'h0000, 16'(tx_buffer_empty_flag_irq));
      gie <= 1'b1;
      csb_v = csb_v & 8'hdf;
      wreg(STXC_OFS_CSB, csb_v);
      ticks(3);
      chk("tx_buffer_empty_flag_masked", 16'h0000, 16'(tx_buffer_empty_flag_irq));
      gie <= 1'b0;
      i = n_frames;
      send(9'h055);
      csb_v = csb_v & 8'hf7;
      wreg(STXC_OFS_CSB, csb_v);
      ticks(20);
      chk("oe_hold", 16'h0001, 16'(txd_oe));
      wait_frames(i);
      chk("frame_drain", exp_frame(9'h055, 8, 0, 0), frame);
      ticks(bit_cyc + 4);
      chk("oe_off", 16'h0000, 16'(txd_oe));
      // synchronous slave: bits advance only on external clock edges
      wreg(STXC_OFS_FMT, 8'h46);
      csb_v = 8'h08;
      wreg(STXC_OFS_CSB, csb_v);
      wreg(STXC_OFS_CSA, 8'h40);
      wreg(STXC_OFS_DATA, 8'h5a);
      ticks(20);
      v0 = txd_o;
      chk("xck_start", 16'h0000, 16'(v0));
      ticks(30);
      chk("xck_hold", 16'(v0), 16'(txd_o));
      d = 9'h000;
      for (int j = 0; j < 12; j++) begin
         xck_in <= 1'b1;
         ticks(4);
         xck_in <= 1'b0;
         ticks(4);
         // one data bit per external rising edge, lsb first
         if (j < 8) d[j] = txd_o;
      end
      chk("xck_bits", 16'h005a, 16'(d[7:0]));
      chk("xck_end_idle", 16'h0001, 16'(txd_o));
      rreg(STXC_OFS_CSA); chk("xck_done", 16'h0060, 16'(rv & 8'h60));
      end_sim();
   end
endmodule : serial_transmitter_core_tb
`default_nettype wire
